// ### core/alis_core.sv
`timescale 1ns/1ns
// Overview of operation
// - pointer add: signed literal -32..31 added to chosen pointer pair, flags unchanged
// - pointer pair result wraps modulo 65536 at both ends
// - AND literal with accumulator, result to accumulator, only zero flag updated
// - add literal to accumulator, result to accumulator, carry, half and zero updated
// - AND accumulator with file register, only zero flag updated
// - destination bit zero selects accumulator, one writes the file register back
// - add accumulator and file register to destination, carry, half and zero updated
// - shift file right keeping bit 7, bit 0 to carry, zero updated
// - add accumulator, file register and carry to destination, all three flags updated
module alis_core (
  input  wire logic                            core_clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            op_valid_i,
  input  wire alis_pkg::alis_op_t              op_i,
  input  wire logic [alis_pkg::DATA_W-1:0]     literal_i,
  input  wire logic                            ptr_sel_i,
  input  wire logic [alis_pkg::FADDR_W-1:0]    file_addr_i,
  input  wire logic                            dest_i,
  input  wire logic [alis_pkg::DATA_W-1:0]     file_rdata_i,
  output logic                                 file_we_o,
  output logic [alis_pkg::FADDR_W-1:0]         file_waddr_o,
  output logic [alis_pkg::DATA_W-1:0]          file_wdata_o,
  output logic [alis_pkg::DATA_W-1:0]          acc_o,
  output logic [alis_pkg::PTR_W-1:0]           ptr0_o,
  output logic [alis_pkg::PTR_W-1:0]           ptr1_o,
  output logic                                 arith_out_flag_o,
  output logic                                 half_nibble_flag_o,
  output logic                                 null_result_flag_o
);
  localparam int unsigned DW = alis_pkg::DATA_W;
  localparam int unsigned NW = alis_pkg::NIB_W;

  logic [DW-1:0]             acc_q;
  logic [alis_pkg::PTR_W-1:0] ptr_q [alis_pkg::N_PTR];
  logic                      c_q;
  logic                      dc_q;
  logic                      z_q;

  logic [DW-1:0]             res;
  logic                      res_c;
  logic                      res_dc;
  logic                      upd_c;
  logic                      upd_dc;
  logic                      upd_z;
  logic                      to_file;
  logic                      to_acc;
  logic [alis_pkg::PTR_W-1:0] ptr_sum;

  function automatic logic [DW+1:0] add3(input logic [DW-1:0] a,
                                         input logic [DW-1:0] b,
                                         input logic          ci);
    logic [NW:0] lo;
    logic [DW:0] full;
    lo   = {1'b0, a[NW-1:0]} + {1'b0, b[NW-1:0]} + {{NW{1'b0}}, ci};
    full = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, ci};
    return {lo[NW], full};
  endfunction : add3

  // sign extension of the 6-bit literal; 16-bit add drops carry for wrap
  assign ptr_sum = ptr_q[ptr_sel_i] +
    {{(alis_pkg::PTR_W-alis_pkg::LIT_S_W){literal_i[alis_pkg::LIT_S_W-1]}},
     literal_i[alis_pkg::LIT_S_W-1:0]};

  always_comb begin
    logic [DW+1:0] s;
    s       = '0;
    res     = acc_q;
    res_c   = c_q;
    res_dc  = dc_q;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    to_file = 1'b0;
    to_acc  = 1'b0;
    if (op_valid_i) begin
      unique case (op_i)
        alis_pkg::ALIS_OP_AND_LIT_ACC: begin
          res    = acc_q & literal_i;
          upd_z  = 1'b1;
          to_acc = 1'b1;
        end
        alis_pkg::ALIS_OP_ADD_LIT_ACC: begin
          s      = add3(acc_q, literal_i, 1'b0);
          res    = s[DW-1:0];
          res_c  = s[DW];
          res_dc = s[DW+1];
          {upd_c, upd_dc, upd_z} = 3'h7;
          to_acc = 1'b1;
        end
        alis_pkg::ALIS_OP_AND_ACC_FILE: begin
          res   = acc_q & file_rdata_i;
          upd_z = 1'b1;
          to_file = (dest_i == alis_pkg::DEST_FILE);
          to_acc  = (dest_i == alis_pkg::DEST_ACC);
        end
        alis_pkg::ALIS_OP_ADD_ACC_FILE,
        alis_pkg::ALIS_OP_ADD_ACC_FILE_C: begin
          // carry-in only for the carry variant
          s = add3(acc_q, file_rdata_i,
                   (op_i == alis_pkg::ALIS_OP_ADD_ACC_FILE_C) & c_q);
          res    = s[DW-1:0];
          res_c  = s[DW];
          res_dc = s[DW+1];
          {upd_c, upd_dc, upd_z} = 3'h7;
          to_file = (dest_i == alis_pkg::DEST_FILE);
          to_acc  = (dest_i == alis_pkg::DEST_ACC);
        end
        alis_pkg::ALIS_OP_ASR_FILE: begin
          res   = {file_rdata_i[alis_pkg::MSB_BIT], file_rdata_i[DW-1:1]};
          res_c = file_rdata_i[0];
          upd_c = 1'b1;
          upd_z = 1'b1;
          to_file = (dest_i == alis_pkg::DEST_FILE);
          to_acc  = (dest_i == alis_pkg::DEST_ACC);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= alis_pkg::ACC_RST;
    end else if (to_acc) begin
      acc_q <= res;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < alis_pkg::N_PTR; gi++) begin : g_ptr
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ptr_q[gi] <= alis_pkg::PTR_RST;
        end else if (op_valid_i && op_i == alis_pkg::ALIS_OP_PTR_ADD_LIT &&
                     ptr_sel_i == 1'(gi)) begin
          ptr_q[gi] <= ptr_sum;
        end
      end
    end
  endgenerate

  // flags are untouched by the pointer add since no upd_* is raised for it
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c_q  <= 1'b0;
      dc_q <= 1'b0;
      z_q  <= 1'b0;
    end else begin
      if (upd_c) c_q <= res_c;
      if (upd_dc) dc_q <= res_dc;
      if (upd_z) z_q <= (res == '0);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      file_we_o    <= 1'b0;
      file_waddr_o <= '0;
      file_wdata_o <= '0;
    end else begin
      file_we_o <= to_file;
      if (to_file) begin
        file_waddr_o <= file_addr_i;
        file_wdata_o <= res;
      end
    end
  end

  assign acc_o              = acc_q;
  assign ptr0_o             = ptr_q[0];
  assign ptr1_o             = ptr_q[1];
  assign arith_out_flag_o   = c_q;
  assign half_nibble_flag_o = dc_q;
  assign null_result_flag_o = z_q;

  property p_ptr_wrap;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_PTR_ADD_LIT && !ptr_sel_i) |=>
        ptr0_o == 16'($past(ptr0_o) + {{10{$past(literal_i[5])}}, $past(literal_i[5:0])});
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer add wrong");

  property p_ptr_flags;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_PTR_ADD_LIT) |=>
        $stable({arith_out_flag_o, half_nibble_flag_o, null_result_flag_o});
  endproperty
  a_ptr_flags: assert property (p_ptr_flags) else $error("pointer add moved flags");

  property p_and_lit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_AND_LIT_ACC) |=>
        acc_o == ($past(acc_o) & $past(literal_i)) && $stable(arith_out_flag_o)
        && null_result_flag_o == (acc_o == '0);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

  property p_add_lit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_ADD_LIT_ACC) |=>
        {arith_out_flag_o, acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(literal_i)};
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

  property p_and_file;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_AND_ACC_FILE && dest_i) |=>
        file_we_o && file_wdata_o == ($past(acc_o) & $past(file_rdata_i));
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file wrong");

  property p_dest_acc;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i != alis_pkg::ALIS_OP_PTR_ADD_LIT && !dest_i) |=> !file_we_o;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("file written for acc dest");

  property p_add_file;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_ADD_ACC_FILE && !dest_i) |=>
        {arith_out_flag_o, acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(file_rdata_i)};
  endproperty
  a_add_file: assert property (p_add_file) else $error("add file wrong");

  property p_asr;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_ASR_FILE && !dest_i) |=>
        acc_o == {$past(file_rdata_i[7]), $past(file_rdata_i[7:1])}
        && arith_out_flag_o == $past(file_rdata_i[0]);
  endproperty
  a_asr: assert property (p_asr) else $error("shift wrong");

  property p_addc;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_ADD_ACC_FILE_C && !dest_i) |=>
        {arith_out_flag_o, acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(file_rdata_i)}
          + {8'h00, $past(arith_out_flag_o)};
  endproperty
  a_addc: assert property (p_addc) else $error("add with carry wrong");

  property p_dc;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (op_valid_i && op_i == alis_pkg::ALIS_OP_ADD_LIT_ACC) |=>
        half_nibble_flag_o == (({1'b0, $past(acc_o[3:0])} + {1'b0, $past(literal_i[3:0])})
          > 5'h0F) && null_result_flag_o == (acc_o == 8'h00);
  endproperty
  a_dc: assert property (p_dc) else $error("half carry or zero wrong");
endmodule : alis_core

// ### core/alis_pkg.sv
package alis_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PTR_W    = 16;
  localparam int unsigned FADDR_W  = 7;
  localparam int unsigned LIT_S_W  = 6;
  localparam int unsigned MSB_BIT  = 7;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned N_PTR    = 2;

  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST   = 16'h0000;
  localparam logic              DEST_ACC  = 1'b0;
  localparam logic              DEST_FILE = 1'b1;

  typedef enum logic [3:0] {
    ALIS_OP_NONE,
    ALIS_OP_PTR_ADD_LIT,
    ALIS_OP_AND_LIT_ACC,
    ALIS_OP_ADD_LIT_ACC,
    ALIS_OP_AND_ACC_FILE,
    ALIS_OP_ADD_ACC_FILE,
    ALIS_OP_ASR_FILE,
    ALIS_OP_ADD_ACC_FILE_C
  } alis_op_t;
endpackage : alis_pkg

// ### sim/tb_alis_core.sv
`timescale 1ns/1ns
module tb_alis_core;
  localparam alis_pkg::alis_op_t NOP   = alis_pkg::ALIS_OP_NONE;
  localparam alis_pkg::alis_op_t P_ADD = alis_pkg::ALIS_OP_PTR_ADD_LIT;
  localparam alis_pkg::alis_op_t L_AND = alis_pkg::ALIS_OP_AND_LIT_ACC;
  localparam alis_pkg::alis_op_t L_ADD = alis_pkg::ALIS_OP_ADD_LIT_ACC;
  localparam alis_pkg::alis_op_t F_AND = alis_pkg::ALIS_OP_AND_ACC_FILE;
  localparam alis_pkg::alis_op_t F_ADD = alis_pkg::ALIS_OP_ADD_ACC_FILE;
  localparam alis_pkg::alis_op_t F_SHR = alis_pkg::ALIS_OP_ASR_FILE;
  localparam alis_pkg::alis_op_t F_ADC = alis_pkg::ALIS_OP_ADD_ACC_FILE_C;
  logic               core_clk_i   = 1'b0;
  logic               reset_n_i    = 1'b0;
  logic               op_valid_i   = 1'b0;
  alis_pkg::alis_op_t op_i         = NOP;
  logic [7:0]         literal_i    = 8'h00;
  logic               ptr_sel_i    = 1'b0;
  logic [6:0]         file_addr_i  = 7'h00;
  logic               dest_i       = 1'b0;
  logic [7:0]         file_rdata_i = 8'h00;
  logic               file_we_o;
  logic [6:0]         file_waddr_o;
  logic [7:0]         file_wdata_o;
  logic [7:0]         acc_o;
  logic [15:0]        ptr0_o;
  logic [15:0]        ptr1_o;
  logic               arith_out_flag_o;
  logic               half_nibble_flag_o;
  logic               null_result_flag_o;
  int                 error_cnt    = 0;
  int                 checks       = 0;
  logic [7:0]         m_acc        = 8'h00;
  logic [15:0]        m_p [2]      = '{16'h0000, 16'h0000};
  logic               m_c          = 1'b0;
  logic               m_dc         = 1'b0;
  logic               m_z          = 1'b0;

  alis_core dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .literal_i(literal_i), .ptr_sel_i(ptr_sel_i), .file_addr_i(file_addr_i),
    .dest_i(dest_i), .file_rdata_i(file_rdata_i), .file_we_o(file_we_o),
    .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o),
    .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .arith_out_flag_o(arith_out_flag_o),
    .half_nibble_flag_o(half_nibble_flag_o), .null_result_flag_o(null_result_flag_o));

  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // drives one op at a falling edge, models it, then checks all outputs at the next falling edge, file address and data only when written
  task automatic run(input logic v, input alis_pkg::alis_op_t op, input logic [7:0] lit,
                     input logic sel, input logic [6:0] fa, input logic d, input logic [7:0] fd);
    logic [7:0] b;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    logic       wr;
    logic [2:0] fg;
    wr = 1'b0;
    op_valid_i = v;
    op_i = op;
    literal_i = lit;
    ptr_sel_i = sel;
    file_addr_i = fa;
    dest_i = d;
    file_rdata_i = fd;
    if (!v) op = NOP;
    b  = (op == L_AND || op == L_ADD) ? lit : fd;
    ci = (op == F_ADC) ? m_c : 1'b0;
    s  = {1'b0, m_acc} + {1'b0, b} + {8'h00, ci};
    h  = {1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    r  = s[7:0];
    if (op == L_AND || op == F_AND) r = m_acc & b;
    if (op == F_SHR) r = {fd[7], fd[7:1]};
    if (op == P_ADD) m_p[sel] = m_p[sel] + {{10{lit[5]}}, lit[5:0]};
    if (op == L_ADD || op == F_ADD || op == F_ADC) begin
      m_c  = s[8];
      m_dc = h[4];
    end
    if (op == F_SHR) m_c = fd[0];
    if (op != NOP && op != P_ADD) begin
      m_z = (r == 8'h00);
      wr  = d && op inside {F_AND, F_ADD, F_SHR, F_ADC};
      if (!wr) m_acc = r;
    end
    @(negedge core_clk_i);
    fg = {arith_out_flag_o, half_nibble_flag_o, null_result_flag_o};
    chk(16'(acc_o), 16'(m_acc), "accumulator");
    chk(ptr0_o, m_p[0], "pointer pair 0");
    chk(ptr1_o, m_p[1], "pointer pair 1");
    chk(16'(fg), 16'({m_c, m_dc, m_z}), "flags");
    chk(16'(file_we_o), 16'(wr), "file write strobe");
    if (wr) begin
      chk(16'(file_waddr_o), 16'(fa), "file write address");
      chk(16'(file_wdata_o), 16'(r), "file write data");
    end
  endtask : run

  task automatic s_idle;
    run(1'b1, NOP, 8'hFF, 1'b1, 7'h7F, 1'b1, 8'hFF);
    run(1'b0, L_ADD, 8'hFF, 1'b1, 7'h7F, 1'b1, 8'hFF);
    op_valid_i = 1'b0;
    @(negedge core_clk_i);
  endtask : s_idle

  task automatic s_lit;
    run(1'b1, L_ADD, 8'h8F, 1'b0, 7'h00, 1'b1, 8'h00);
    run(1'b1, L_ADD, 8'h71, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, L_AND, 8'hFF, 1'b0, 7'h00, 1'b1, 8'h00);
    run(1'b1, L_ADD, 8'hA5, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, L_AND, 8'h5A, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, L_ADD, 8'h3C, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, L_AND, 8'h0F, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, L_ADD, 8'hF8, 1'b0, 7'h00, 1'b0, 8'h00);
  endtask : s_lit

  // carry and half flags are left set (zero clear) by s_lit so that an unwanted flag update shows
  task automatic s_ptr;
    run(1'b1, P_ADD, 8'h1F, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, P_ADD, 8'hE0, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, P_ADD, 8'h01, 1'b0, 7'h00, 1'b0, 8'h00);
    run(1'b1, P_ADD, 8'hDF, 1'b1, 7'h00, 1'b1, 8'h00);
    run(1'b1, P_ADD, 8'h20, 1'b1, 7'h00, 1'b0, 8'h00);
    run(1'b1, P_ADD, 8'h20, 1'b1, 7'h00, 1'b0, 8'h00);
  endtask : s_ptr

  task automatic s_file;
    run(1'b1, F_ADD, 8'h00, 1'b0, 7'h7F, 1'b1, 8'hFC);
    run(1'b1, F_ADC, 8'h00, 1'b0, 7'h00, 1'b0, 8'h10);
    run(1'b1, F_ADC, 8'h00, 1'b0, 7'h12, 1'b1, 8'hEA);
    run(1'b1, F_SHR, 8'h00, 1'b0, 7'h55, 1'b1, 8'h81);
    run(1'b1, F_SHR, 8'h00, 1'b0, 7'h01, 1'b0, 8'h01);
    run(1'b1, F_ADC, 8'h00, 1'b0, 7'h33, 1'b1, 8'h0F);
    run(1'b1, F_AND, 8'h00, 1'b0, 7'h2A, 1'b1, 8'hEF);
    run(1'b1, F_AND, 8'h00, 1'b0, 7'h2A, 1'b0, 8'hFF);
    run(1'b1, F_ADD, 8'h00, 1'b0, 7'h40, 1'b0, 8'h08);
  endtask : s_file

  task automatic results;
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    repeat (12) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    s_idle();
    s_lit();
    s_ptr();
    s_file();
    s_idle();
    results();
  end
endmodule : tb_alis_core
